// *** hdl/ufb_pkg.sv ***
`default_nettype none
package ufb_pkg;
   // fifo side data word
   localparam int BUS_BYTES = 4;
   typedef struct packed {
      logic [8*BUS_BYTES-1:0] data;
      logic [BUS_BYTES-1:0]   be;
   } ufb_word_type;

   // fifo clock codes
   localparam logic [1:0] CLK_100 = 2'h0;
   localparam logic [1:0] CLK_66  = 2'h1;
   localparam logic [1:0] CLK_50  = 2'h2;

   // channel layout codes
   localparam logic [2:0] CHAN_4   = 3'h0;
   localparam logic [2:0] CHAN_2   = 3'h1;
   localparam logic [2:0] CHAN_1   = 3'h2;
   localparam logic [2:0] CHAN_OUT = 3'h3;
   localparam logic [2:0] CHAN_IN  = 3'h4;

   // stored configuration word
   typedef struct packed {
      logic [1:0] clk_sel;
      logic       multi_ch;
      logic [2:0] chans;
      logic       bc_en;
      logic       ign_ur;
      logic       sub_pkt;
      logic       sub_bw;
   } ufb_cfg_type;
   localparam ufb_cfg_type CFG_DEFAULT = '{CLK_100, 1'b1, CHAN_4,
                                           1'b0, 1'b0, 1'b0, 1'b0};

   // detector result and gpio codes
   typedef enum logic [1:0] {PORT_NONE, PORT_SDP, PORT_CDP, PORT_DCP}
      ufb_port_type;
   localparam logic [1:0] GPIO_DCP  = 2'h3;
   localparam logic [1:0] GPIO_CDP  = 2'h2;
   localparam logic [1:0] GPIO_SDP  = 2'h1;
   localparam logic [1:0] GPIO_NONE = 2'h0;

   // register byte offsets and status bits
   localparam logic [7:0] OFF_CFG    = 8'h00;
   localparam logic [7:0] OFF_REQ    = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_COUNT  = 8'h0C;
   localparam logic [7:0] OFF_BC     = 8'h10;
   localparam int ST_OPEN = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FALLBACK = 2;

   typedef enum logic [1:0] {S_INIT, S_IDLE, S_OPEN} ufb_state_type;
endpackage : ufb_pkg
`default_nettype wire

// *** hdl/ufb_bridge.sv ***
// How it works
// [R1] fifo clock rate is configurable, 100 MHz code when nothing stored
// [R2] single or multi-channel fifo protocol, multi-channel by default
// [R3] the external master must speak the same protocol as configured
// [R4] four, two or one channel, or single out or in pipe; four default
// [R5] port type detection only when enabled; disabled by default
// [R6] gpio shows 11 dcp, 10 cdp, 01 sdp, 00 otherwise
// [R7] without underrun ignore, a pause closes the session with its count
// [R8] with underrun ignore, session stays open until requested length
// [R9] two exclusive sub-modes, only with underrun ignore, none by default
// [R10] bus-width sub-mode exists only on the later silicon revision
// [R11] packet sub-mode: non-multiple burst or full length closes
// [R12] bus-width sub-mode: partial-word burst or full length closes
// [R13] bus-width sub-mode releases usb data only with a full buffer; the code also releases a partial buffer once the session closes
// [R14] stored config applied once after reset, defaults if empty or bad
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ufb_bridge #(
   parameter int MPS_BYTES = 1024,
   parameter bit LATER_REV = 1'b1
) (
   input  wire logic                  core_clk_i,
   input  wire logic                  reset_i,
   input  wire logic                  hsel_i,
   input  wire logic [31:0]           haddr_i,
   input  wire logic [1:0]            htrans_i,
   input  wire logic                  hwrite_i,
   input  wire logic [2:0]            hsize_i,
   input  wire logic [31:0]           hwdata_i,
   input  wire logic                  hready_i,
   output logic      [31:0]           hrdata_o,
   output logic                       hreadyout_o,
   output logic                       hresp_o,
   input  wire ufb_pkg::ufb_cfg_type  nv_cfg_i,
   input  wire logic                  nv_cfg_valid_i,
   input  wire logic                  fifo_wr_i,
   input  wire ufb_pkg::ufb_word_type fifo_word_i,
   output logic                       fifo_ready_o,
   output ufb_pkg::ufb_word_type      usb_word_o,
   output logic                       usb_valid_o,
   input  wire logic                  usb_ready_i,
   input  wire logic                  bc_valid_i,
   input  wire ufb_pkg::ufb_port_type bc_port_i,
   output logic      [1:0]            bc_gpio_o,
   output logic      [1:0]            fifo_clk_sel_o,
   output logic                       fifo_multi_ch_o,
   output logic      [3:0]            out_pipe_en_o,
   output logic      [3:0]            in_pipe_en_o,
   output logic                       session_open_o
);
   localparam int MW = $clog2(MPS_BYTES);

   // pipe enables per channel layout, {out, in}
   function automatic logic [7:0] pipe_en(input logic [2:0] ch);
      case (ch)
         ufb_pkg::CHAN_4:   pipe_en = 8'hFF;
         ufb_pkg::CHAN_2:   pipe_en = 8'h33;
         ufb_pkg::CHAN_1:   pipe_en = 8'h11;
         ufb_pkg::CHAN_OUT: pipe_en = 8'h10;
         ufb_pkg::CHAN_IN:  pipe_en = 8'h01;
         default:           pipe_en = 8'h00;
      endcase
   endfunction : pipe_en

   // consistency check of a stored word
   function automatic logic cfg_ok(input ufb_pkg::ufb_cfg_type c);
      cfg_ok = (c.chans <= ufb_pkg::CHAN_IN)
             && (c.clk_sel <= ufb_pkg::CLK_50)
             && !(c.sub_pkt && c.sub_bw)
             && ((!c.sub_pkt && !c.sub_bw) || c.ign_ur)
             && (!c.sub_bw || LATER_REV);
   endfunction : cfg_ok

   // bytes carried by one word
   function automatic logic [31:0] bytes_of(
      input logic [ufb_pkg::BUS_BYTES-1:0] be);
      bytes_of = '0;
      for (int i = 0; i < ufb_pkg::BUS_BYTES; i++) begin
         bytes_of = bytes_of + {31'h0, be[i]};
      end
   endfunction : bytes_of

   ufb_pkg::ufb_state_type state;
   ufb_pkg::ufb_cfg_type   cfg, load_cfg;
   ufb_pkg::ufb_word_type  tail;
   logic                   fallback, done, in_burst, burst_part, a_wr;
   logic                   next_open, next_valid, bw_mode, accept, pop;
   logic                   reach, burst_end, close_burst, close, start;
   logic                   load_ok;
   logic [31:0]            req_len, byte_cnt, rdata, nbytes, sum;
   logic [MW-1:0]          burst_mod;
   logic [1:0]             buf_cnt, next_cnt;
   logic [7:0]             a_addr, pipes;
   assign load_ok  = nv_cfg_valid_i && cfg_ok(nv_cfg_i);
   assign load_cfg = load_ok ? nv_cfg_i : ufb_pkg::CFG_DEFAULT;
   assign pipes    = pipe_en(load_cfg.chans);

   // configuration latched once, in the first cycle after reset
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg             <= ufb_pkg::CFG_DEFAULT;
         fallback        <= 1'b0;
         fifo_clk_sel_o  <= ufb_pkg::CLK_100;
         fifo_multi_ch_o <= 1'b1;
         out_pipe_en_o   <= 4'h0;
         in_pipe_en_o    <= 4'h0;
      end else if (state == ufb_pkg::S_INIT) begin
         cfg             <= load_cfg; // R14 R9 R10
         fallback        <= !load_ok; // R14
         fifo_clk_sel_o  <= load_cfg.clk_sel; // R1
         fifo_multi_ch_o <= load_cfg.multi_ch; // R2 R3
         out_pipe_en_o   <= pipes[7:4]; // R4
         in_pipe_en_o    <= pipes[3:0]; // R4
      end
   end

   // port type on the gpio pair
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bc_gpio_o <= ufb_pkg::GPIO_NONE;
      end else if (!cfg.bc_en || !bc_valid_i) begin
         bc_gpio_o <= ufb_pkg::GPIO_NONE; // R5
      end else begin
         case (bc_port_i)
            ufb_pkg::PORT_DCP: bc_gpio_o <= ufb_pkg::GPIO_DCP; // R6
            ufb_pkg::PORT_CDP: bc_gpio_o <= ufb_pkg::GPIO_CDP; // R6
            ufb_pkg::PORT_SDP: bc_gpio_o <= ufb_pkg::GPIO_SDP; // R6
            default:           bc_gpio_o <= ufb_pkg::GPIO_NONE;
         endcase
      end
   end
   // session events
   assign bw_mode   = cfg.ign_ur && cfg.sub_bw;
   assign accept    = fifo_wr_i && fifo_ready_o;
   assign pop       = usb_valid_o && usb_ready_i;
   assign nbytes    = accept ? bytes_of(fifo_word_i.be) : 32'h0;
   assign sum       = byte_cnt + nbytes;
   assign reach     = accept && (sum >= req_len);
   assign burst_end = in_burst && fifo_ready_o && !fifo_wr_i;
   assign close_burst = burst_end && (!cfg.ign_ur // R7
      || (cfg.sub_pkt && burst_mod != '0) // R11
      || (cfg.sub_bw && burst_part)); // R12
   assign close = (state == ufb_pkg::S_OPEN) && (reach || close_burst);
   assign start = a_wr && (a_addr == ufb_pkg::OFF_REQ)
                  && (state == ufb_pkg::S_IDLE) && (hwdata_i != 32'h0);
   // session state and counts
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state      <= ufb_pkg::S_INIT;
         req_len    <= 32'h0;
         byte_cnt   <= 32'h0;
         in_burst   <= 1'b0;
         burst_part <= 1'b0;
         burst_mod  <= '0;
      end else begin
         case (state)
            ufb_pkg::S_INIT: begin
               state <= ufb_pkg::S_IDLE;
            end
            ufb_pkg::S_IDLE: begin
               if (start) begin
                  state      <= ufb_pkg::S_OPEN;
                  req_len    <= hwdata_i;
                  byte_cnt   <= 32'h0;
                  in_burst   <= 1'b0;
                  burst_part <= 1'b0;
                  burst_mod  <= '0;
               end
            end
            ufb_pkg::S_OPEN: begin
               byte_cnt <= sum;
               if (close) begin
                  state <= ufb_pkg::S_IDLE; // R7 R11 R12
               end
               if (accept) begin
                  in_burst   <= 1'b1;
                  burst_mod  <= burst_mod + nbytes[MW-1:0];
                  burst_part <= burst_part || !(&fifo_word_i.be);
               end else if (burst_end) begin
                  in_burst   <= 1'b0; // R8 pause kept open
                  burst_mod  <= '0;
                  burst_part <= 1'b0;
               end
            end
            default: state <= ufb_pkg::S_IDLE;
         endcase
      end
   end
   // sticky completion flag, set beats a clear
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         done <= 1'b0;
      end else if (close) begin
         done <= 1'b1; // R7
      end else if (a_wr && (a_addr == ufb_pkg::OFF_STATUS)
                   && hwdata_i[ufb_pkg::ST_DONE]) begin
         done <= 1'b0;
      end
   end
   // two-entry buffer bookkeeping
   always_comb begin
      next_cnt   = buf_cnt + {1'b0, accept} - {1'b0, pop};
      next_open  = (state == ufb_pkg::S_OPEN) ? !close : start;
      next_valid = (next_cnt != 2'h0)
                   && (!bw_mode || next_cnt == 2'h2 || !next_open); // R13
   end
   // buffer storage and handshakes
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         buf_cnt        <= 2'h0;
         usb_word_o     <= '0;
         tail           <= '0;
         usb_valid_o    <= 1'b0;
         fifo_ready_o   <= 1'b0;
         session_open_o <= 1'b0;
      end else begin
         buf_cnt        <= next_cnt;
         usb_valid_o    <= next_valid; // R13
         fifo_ready_o   <= next_open && (next_cnt != 2'h2);
         session_open_o <= next_open;
         if (pop) begin
            usb_word_o <= (buf_cnt == 2'h2) ? tail : fifo_word_i;
         end else if (accept && buf_cnt == 2'h0) begin
            usb_word_o <= fifo_word_i;
         end
         if (accept && !pop && buf_cnt == 2'h1) begin
            tail <= fifo_word_i;
         end
      end
   end

   // register read mux
   always_comb begin
      case (haddr_i[7:0])
         ufb_pkg::OFF_CFG:    rdata = {22'h0, cfg};
         ufb_pkg::OFF_REQ:    rdata = req_len;
         ufb_pkg::OFF_STATUS: rdata = {29'h0, fallback, done,
                                       state == ufb_pkg::S_OPEN};
         ufb_pkg::OFF_COUNT:  rdata = byte_cnt;
         ufb_pkg::OFF_BC:     rdata = {30'h0, bc_gpio_o};
         default:             rdata = 32'h0;
      endcase
   end

   // ahb-lite slave, zero wait, always okay
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         a_wr        <= 1'b0;
         a_addr      <= 8'h0;
         hrdata_o    <= 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         a_wr        <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
         a_addr      <= haddr_i[7:0];
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
            hrdata_o <= rdata;
         end
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   property p_dflt_clk;
      (state == ufb_pkg::S_INIT && !nv_cfg_valid_i)
         |=> fifo_clk_sel_o == ufb_pkg::CLK_100 && fifo_multi_ch_o;
   endproperty
   a_dflt_clk: assert property (p_dflt_clk) // R1 R2
      else $error("default clock or protocol not applied");
   property p_dflt_pipes;
      (state == ufb_pkg::S_INIT && !nv_cfg_valid_i)
         |=> out_pipe_en_o == 4'hF && in_pipe_en_o == 4'hF;
   endproperty
   a_dflt_pipes: assert property (p_dflt_pipes) // R4
      else $error("default four channels not applied");
   property p_bc_off;
      !cfg.bc_en |=> bc_gpio_o == ufb_pkg::GPIO_NONE;
   endproperty
   a_bc_off: assert property (p_bc_off) // R5
      else $error("gpio driven while detection disabled");
   property p_bc_dcp;
      cfg.bc_en && bc_valid_i && bc_port_i == ufb_pkg::PORT_DCP
         ##1 cfg.bc_en |-> bc_gpio_o == ufb_pkg::GPIO_DCP;
   endproperty
   a_bc_dcp: assert property (p_bc_dcp) // R6
      else $error("dcp code wrong");
   property p_pause_close;
      state == ufb_pkg::S_OPEN && burst_end && !cfg.ign_ur
         |=> state == ufb_pkg::S_IDLE && done;
   endproperty
   a_pause_close: assert property (p_pause_close) // R7
      else $error("pause did not end the session");
   property p_ignore_open;
      state == ufb_pkg::S_OPEN && cfg.ign_ur && !cfg.sub_pkt
         && !cfg.sub_bw && !reach |=> state == ufb_pkg::S_OPEN;
   endproperty
   a_ignore_open: assert property (p_ignore_open) // R8
      else $error("session closed before length");
   property p_sub_excl;
      !(cfg.sub_pkt && cfg.sub_bw)
         && (cfg.ign_ur || (!cfg.sub_pkt && !cfg.sub_bw));
   endproperty
   a_sub_excl: assert property (p_sub_excl) // R9
      else $error("sub-modes inconsistent");
   property p_rev;
      cfg.sub_bw |-> LATER_REV && cfg.ign_ur;
   endproperty
   a_rev: assert property (p_rev) // R10
      else $error("bus-width sub-mode on early revision");
   property p_pkt_close;
      state == ufb_pkg::S_OPEN && burst_end && cfg.sub_pkt
         && burst_mod != '0 |=> state == ufb_pkg::S_IDLE;
   endproperty
   a_pkt_close: assert property (p_pkt_close) // R11
      else $error("odd burst did not close");
   property p_reach;
      state == ufb_pkg::S_OPEN && reach
         |=> state == ufb_pkg::S_IDLE && done;
   endproperty
   a_reach: assert property (p_reach) // R12
      else $error("length reached but session open");
   property p_bw_full;
      usb_valid_o && bw_mode && session_open_o |-> buf_cnt == 2'h2;
   endproperty
   a_bw_full: assert property (p_bw_full) // R13
      else $error("usb data released before buffer full");
   property p_cfg_stable;
      state != ufb_pkg::S_INIT |=> $stable(cfg);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) // R14
      else $error("configuration changed after init");
   c_pause: cover property (state == ufb_pkg::S_OPEN && close_burst);
   c_reach: cover property (state == ufb_pkg::S_OPEN && reach);
   c_stall: cover property (buf_cnt == 2'h2 && !usb_ready_i);
endmodule : ufb_bridge
`default_nettype wire

// *** dv/ufb_fifo_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// fifo master model: bursts of sequential words on the write strobe
module ufb_fifo_master (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             start_i,
   input  wire logic [7:0]       nwords_i,
   input  wire logic [3:0]       last_be_i,
   input  wire logic             fifo_ready_i,
   output logic                  fifo_wr_o,
   output ufb_pkg::ufb_word_type fifo_word_o,
   output logic                  busy_o
);
   logic [7:0]  left;
   logic [31:0] seq;
   assign busy_o = (left != 8'h00);
   // strobe and word held until taken, released lines show the inverse
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         left        <= 8'h00;
         seq         <= 32'h0000_0000;
         fifo_wr_o   <= 1'b0;
         fifo_word_o <= '0;
      end else if (start_i && !busy_o) begin
         left        <= nwords_i;
         fifo_wr_o   <= 1'b1;
         fifo_word_o <= {seq, (nwords_i == 8'h01) ? last_be_i : 4'hf};
      end else if (fifo_wr_o && fifo_ready_i) begin
         seq  <= seq + 32'h1;
         left <= left - 8'h01;
         if (left == 8'h01) begin
            fifo_wr_o   <= 1'b0;
            fifo_word_o <= ~fifo_word_o;
         end else begin
            fifo_word_o <= {seq + 32'h1, (left == 8'h02) ? last_be_i : 4'hf};
         end
      end
   end
endmodule : ufb_fifo_master
`default_nettype wire

// *** dv/test_usb_fifo_bridge_session_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_usb_fifo_bridge_session_config;
   localparam int MPS = 16;
   logic                  core_clk_i = 1'b0;
   logic                  reset_i    = 1'b1;
   logic                  hsel_i     = 1'b0;
   logic [31:0]           haddr_i    = 32'h0000_0000;
   logic [1:0]            htrans_i   = 2'h0;
   logic                  hwrite_i   = 1'b0;
   logic [31:0]           hwdata_i   = 32'h0000_0000;
   ufb_pkg::ufb_cfg_type  nv_cfg_i   = '0;
   logic                  nv_cfg_valid_i = 1'b0;
   logic                  usb_ready_i = 1'b0;
   logic                  bc_valid_i = 1'b0;
   ufb_pkg::ufb_port_type bc_port_i  = ufb_pkg::PORT_NONE;
   logic                  start = 1'b0;
   logic [7:0]            nwords = 8'h00;
   logic [3:0]            last_be = 4'hf;
   logic                  sink_en = 1'b0;
   logic [31:0]           hrdata_o;
   logic                  hreadyout_o, hresp_o, fifo_wr, fifo_ready_o;
   logic                  usb_valid_o, fifo_multi_ch_o, session_open_o, busy;
   ufb_pkg::ufb_word_type fifo_word, usb_word_o;
   logic [1:0]            bc_gpio_o, fifo_clk_sel_o;
   logic [3:0]            out_pipe_en_o, in_pipe_en_o;
   logic [31:0]           exp_seq, rd;
   logic [10:0]           tbl [10] = '{11'h080, 11'h5A8, 11'h610, 11'h4B4,
      11'h4C6, 11'h485, 11'h4D0, 11'h780, 11'h482, 11'h487};
   int                    seed, failures, tests_run, cycles, n;

   ufb_bridge #(.MPS_BYTES(MPS), .LATER_REV(1'b1)) u_ufb_bridge (
      .core_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
      .hreadyout_o, .hresp_o, .nv_cfg_i, .nv_cfg_valid_i,
      .fifo_wr_i(fifo_wr), .fifo_word_i(fifo_word), .fifo_ready_o,
      .usb_word_o, .usb_valid_o, .usb_ready_i, .bc_valid_i, .bc_port_i,
      .bc_gpio_o, .fifo_clk_sel_o, .fifo_multi_ch_o, .out_pipe_en_o,
      .in_pipe_en_o, .session_open_o);
   ufb_fifo_master u_ufb_fifo_master (.clk_i(core_clk_i), .reset_i,
      .start_i(start), .nwords_i(nwords), .last_be_i(last_be),
      .fifo_ready_i(fifo_ready_o), .fifo_wr_o(fifo_wr),
      .fifo_word_o(fifo_word), .busy_o(busy));

   always #10 core_clk_i = ~core_clk_i;

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   // active config expected, defaults when stored word is absent or bad
   function automatic ufb_pkg::ufb_cfg_type exp_cfg(input logic [10:0] t);
      ufb_pkg::ufb_cfg_type c;
      c = t[9:0];
      if (t[10] && c.chans <= 3'h4 && c.clk_sel <= 2'h2
          && !(c.sub_pkt && c.sub_bw)
          && (c.ign_ur || !(c.sub_pkt || c.sub_bw)))
         return c;
      return ufb_pkg::CFG_DEFAULT;
   endfunction : exp_cfg

   // out and in pipe enables for a channel code
   function automatic logic [7:0] exp_pipes(input logic [2:0] ch);
      case (ch)
         ufb_pkg::CHAN_2:   return 8'h33;
         ufb_pkg::CHAN_1:   return 8'h11;
         ufb_pkg::CHAN_OUT: return 8'h10;
         ufb_pkg::CHAN_IN:  return 8'h01;
         default:           return 8'hff;
      endcase
   endfunction : exp_pipes

   // one ahb-lite single word transfer
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0000_00, a};
      hwrite_i <= w;
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask : bus

   task automatic do_reset(input logic [10:0] t);
      reset_i <= 1'b1;
      nv_cfg_i <= t[9:0];
      nv_cfg_valid_i <= t[10];
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
   endtask : do_reset

   // 0 model busy, 1 session open, 2 usb valid: wait for it to drop
   task automatic wait_low(input int k);
      int m;
      m = 0;
      do begin
         @(posedge core_clk_i);
         m++;
      end while (m < 300 && (k == 0 ? busy : k == 1 ? session_open_o
                 : usb_valid_o) !== 1'b0);
      if (m == 300) check(32'(k), 32'hffff_ffff);
   endtask : wait_low

   task automatic burst(input int w, input logic [3:0] be, input logic hold);
      nwords <= 8'(w);
      last_be <= be;
      start <= 1'b1;
      @(posedge core_clk_i);
      start <= 1'b0;
      if (hold) wait_low(0);
   endtask : burst

   task automatic session(input logic [10:0] t, input logic [31:0] req);
      do_reset(t);
      bus(1'b1, ufb_pkg::OFF_REQ, req);
   endtask : session

   task automatic closed_count(input logic [31:0] bytes);
      wait_low(1);
      bus(1'b0, ufb_pkg::OFF_COUNT, 32'h0);
      check(rd, bytes);
   endtask : closed_count

   // usb sink with random stalls, checks word order
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         exp_seq <= 32'h0000_0000;
      end else begin
         if (usb_valid_o === 1'b1 && usb_ready_i === 1'b1) begin
            check(usb_word_o.data, exp_seq);
            exp_seq <= exp_seq + 32'h1;
         end
         usb_ready_i <= sink_en && ($random(seed) & 1);
      end
   end

   // run limit
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         $display("wrong value at %0t: run too long", $time);
         print_verdict;
      end
   end

   initial begin
      seed = 19805;
      sink_en <= 1'b1;
      foreach (tbl[i]) begin
         do_reset(tbl[i]);
         check(32'(fifo_clk_sel_o), 32'(exp_cfg(tbl[i]).clk_sel));
         check(32'(fifo_multi_ch_o), 32'(exp_cfg(tbl[i]).multi_ch));
         check(32'({out_pipe_en_o, in_pipe_en_o}),
               32'(exp_pipes(exp_cfg(tbl[i]).chans)));
         bus(1'b0, ufb_pkg::OFF_CFG, 32'h0);
         check(rd, 32'(exp_cfg(tbl[i])));
         bus(1'b0, ufb_pkg::OFF_STATUS, 32'h0);
         check(32'(rd[2]),
               32'(exp_cfg(tbl[i]) !== tbl[i][9:0] || !tbl[i][10]));
      end
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0000_0000);
      check(32'(hresp_o), 32'h0000_0000);
      // detector codes with detection on, then with it off
      do_reset(11'h488);
      for (int p = 0; p < 5; p++) begin
         bc_port_i <= ufb_pkg::ufb_port_type'(p[1:0]);
         bc_valid_i <= (p < 4);
         repeat (2) @(posedge core_clk_i);
         check(32'(bc_gpio_o), 32'((p < 4) ? p[1:0] : 2'h0));
         bus(1'b0, ufb_pkg::OFF_BC, 32'h0);
         check(rd, 32'((p < 4) ? p[1:0] : 2'h0));
      end
      bc_valid_i <= 1'b1;
      bc_port_i <= ufb_pkg::PORT_DCP;
      do_reset(11'h480);
      check(32'(bc_gpio_o), 32'(ufb_pkg::GPIO_NONE));
      // pause ends a plain session with its count, done is w1c
      n = 1 + ($random(seed) & 7);
      session(11'h480, 32'd64);
      burst(n, 4'hf, 1'b1);
      closed_count(32'(4 * n));
      bus(1'b0, ufb_pkg::OFF_STATUS, 32'h0);
      check(rd & 32'h3, 32'h2);
      bus(1'b1, ufb_pkg::OFF_STATUS, 32'h2);
      bus(1'b0, ufb_pkg::OFF_STATUS, 32'h0);
      check(rd & 32'h3, 32'h0);
      wait_low(2);
      // underrun ignored: open across a pause until length
      session(11'h484, 32'd32);
      burst(3, 4'hf, 1'b1);
      repeat (4) @(posedge core_clk_i);
      check(32'(session_open_o), 32'h1);
      burst(5, 4'hf, 1'b1);
      closed_count(32'd32);
      wait_low(2);
      // packet multiple keeps open, odd burst closes
      session(11'h486, 32'd64);
      burst(MPS / 4, 4'hf, 1'b1);
      repeat (4) @(posedge core_clk_i);
      check(32'(session_open_o), 32'h1);
      burst(3, 4'hf, 1'b1);
      closed_count(32'(MPS + 12));
      wait_low(2);
      // bus-width mode: full buffer before usb, stall fills it
      sink_en <= 1'b0;
      session(11'h485, 32'd64);
      burst(1, 4'hf, 1'b1);
      repeat (4) @(posedge core_clk_i);
      check(32'(session_open_o), 32'h1);
      check(32'(usb_valid_o), 32'h0);
      burst(2, 4'hf, 1'b0);
      repeat (4) @(posedge core_clk_i);
      check(32'(fifo_ready_o), 32'h0);
      check(32'(usb_valid_o), 32'h1);
      sink_en <= 1'b1;
      wait_low(0);
      burst(2, 4'h3, 1'b1);
      closed_count(32'd18);
      wait_low(2);
      print_verdict;
   end
endmodule : test_usb_fifo_bridge_session_config
`default_nettype wire
